// ### design/imr_core.sv
/*
  Idle mode control and reset sequencing of the CPU core.
  Assumes all inputs synchronous to i_clk_sys; vector bytes return one
  cycle after o_vec_rd.
*/
`timescale 1ns/10ps
`default_nettype none
module imr_core (
  input wire logic i_clk_sys, // System clock
  input wire logic i_rst_n, // Power-on reset, active low
  input wire logic i_reset_pin_n, // External reset pin
  input wire logic i_sc2_wr, // Write system_control_two
  input wire logic [7:0] i_wdata, // Software write data
  input wire logic i_trap_en_wr, // Write trap_enable_reg
  input wire logic i_trap_key_wr, // Write trap_key_reg
  input wire logic i_ef_wr, // Write per-source enables
  input wire logic [imr_pkg::NSRC-1:0] i_ef_wdata, // Enable data
  input wire logic i_imf_wr, // Write global enable
  input wire logic i_imf_wdata, // Global enable data
  input wire logic i_psw_wr, // Write bank and jump flag
  input wire logic i_bank_sel_wdata, // Bank selector data
  input wire logic i_jump_flag_wdata, // Jump flag data
  input wire logic i_wdt_dis, // Watchdog disable pulse
  input wire logic i_wdt_overflow, // Watchdog reset request
  input wire logic i_ofd_low, // Frequency below window
  input wire logic i_ofd_high, // Frequency above window
  input wire logic [imr_pkg::NSRC-1:0] i_irq_pending, // interrupt_pending_latch
  input wire logic [19:0] i_pc_plus2, // PC two instructions on
  input wire logic i_fetch_valid, // Instruction fetch strobe
  input wire logic [19:0] i_fetch_addr, // Fetch address
  input wire logic i_swi_exec, // software_trap_instruction runs
  input wire logic [19:0] i_swi_next_pc, // Its incremented PC
  input wire logic [7:0] i_vec_rdata, // Vector byte
  output logic o_core_rst_n, // Core reset, active low
  output imr_pkg::imr_cause_s o_cause, // Causes of last reset
  output logic o_cpu_run, // CPU may execute
  output logic o_wdt_run, // Watchdog may count
  output logic o_periph_run, // Peripherals clocked
  output logic o_idle, // In idle mode
  output logic o_wake_resume, // Wake, resume without vectoring
  output logic o_wake_vector, // Wake into interrupt service
  output logic [19:0] o_resume_pc, // Held PC while idle
  output logic o_vec_rd, // Vector byte read
  output logic [19:0] o_vec_addr, // Vector byte address
  output logic o_start, // Start execution pulse
  output logic [19:0] o_start_pc, // Fetched reset vector
  output logic o_hf_osc_enable, // hf_osc_enable
  output logic o_sysclk_select, // sysclk_select
  output logic [imr_pkg::NSRC-1:0] o_ef, // per_source_interrupt_enable
  output logic o_imf, // global_interrupt_enable
  output logic o_bank_selector, // bank_selector
  output logic o_jump_status_flag, // jump_status_flag
  output logic o_wdt_enable, // Watchdog enabled
  output logic o_trap_permit // Address trap permitted
);
  import imr_pkg::*;

  imr_state_e state_reg;
  imr_cause_s cause;
  logic [3:0] ext_cnt_reg;
  logic ext_rst_reg;
  logic blk_rst_n;
  logic trap_req;
  logic [1:0] vec_idx_reg;
  logic vec_rd_d_reg;
  logic [23:0] vec_buf_reg;
  logic wake_any;

  // Everything but the pin filter, reset merge and o_periph_run follows power-on and core reset
  assign blk_rst_n = i_rst_n && o_core_rst_n;
  assign wake_any = |(i_irq_pending & o_ef);

  // Pin must stay low the full minimum before it counts
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n || i_reset_pin_n)
    begin
      ext_cnt_reg <= 4'h0;
      ext_rst_reg <= 1'b0;
    end
    else if (ext_cnt_reg != 4'(EXT_LOW_CYC - 1))
      ext_cnt_reg <= ext_cnt_reg + 4'h1;
    else
      ext_rst_reg <= 1'b1;
  end

  // Reset causes
  assign cause.ext = ext_rst_reg;
  assign cause.trap = trap_req;
  assign cause.wdt = i_wdt_overflow && o_wdt_enable;
  assign cause.sysclk = !o_hf_osc_enable || o_sysclk_select;
  assign cause.ofd = i_ofd_low || i_ofd_high;

  imr_rst_merge u_rst_merge (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_cause(cause),
    .o_core_rst_n(o_core_rst_n),
    .o_cause(o_cause)
  );

  imr_trap_ctl u_trap_ctl (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(blk_rst_n),
    .i_trap_en_wr(i_trap_en_wr),
    .i_trap_key_wr(i_trap_key_wr),
    .i_wdata(i_wdata),
    .i_fetch_valid(i_fetch_valid),
    .i_fetch_addr(i_fetch_addr),
    .i_swi_exec(i_swi_exec),
    .i_swi_next_pc(i_swi_next_pc),
    .o_permit(o_trap_permit),
    .o_trap_req(trap_req)
  );

  // Oscillator enable and clock select
  always_ff @(posedge i_clk_sys)
  begin
    if (!blk_rst_n)
    begin
      o_hf_osc_enable <= SC2_XEN_RST;
      o_sysclk_select <= SC2_SYSCLK_SELECT_RST;
    end
    else if (i_sc2_wr)
    begin
      o_hf_osc_enable <= i_wdata[SC2_XEN_BIT];
      o_sysclk_select <= i_wdata[SC2_SYSCLK_SELECT_BIT];
    end
  end

  // Interrupt enables
  always_ff @(posedge i_clk_sys)
  begin
    if (!blk_rst_n)
    begin
      o_ef <= '0;
      o_imf <= IMF_RST;
    end
    else
    begin
      if (i_ef_wr)
        o_ef <= i_ef_wdata;
      if (i_imf_wr)
        o_imf <= i_imf_wdata;
    end
  end

  // Bank selector and jump flag; other core state is left alone
  always_ff @(posedge i_clk_sys)
  begin
    if (!blk_rst_n)
    begin
      o_bank_selector <= BANK_SEL_RST;
      o_jump_status_flag <= JUMP_FLAG_RST;
    end
    else if (i_psw_wr && o_cpu_run)
    begin
      o_bank_selector <= i_bank_sel_wdata;
      o_jump_status_flag <= i_jump_flag_wdata;
    end
  end

  // Watchdog stays enabled through reset
  always_ff @(posedge i_clk_sys)
  begin
    if (!blk_rst_n)
      o_wdt_enable <= WDT_EN_RST;
    else if (i_wdt_dis)
      o_wdt_enable <= 1'b0;
  end

  // Peripherals keep their clock whenever power-on is released
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      o_periph_run <= 1'b0;
    else
      o_periph_run <= 1'b1;
  end

  // Sequencer: reset, vector fetch, run, idle
  always_ff @(posedge i_clk_sys)
  begin
    if (!blk_rst_n)
    begin
      state_reg <= S_RST;
      o_cpu_run <= 1'b0;
      o_idle <= 1'b0;
      o_vec_rd <= 1'b0;
      o_vec_addr <= VEC_ADDR_LO;
      vec_idx_reg <= 2'h0;
      o_start <= 1'b0;
      o_wake_resume <= 1'b0;
      o_wake_vector <= 1'b0;
    end
    else
    begin
      o_start <= 1'b0;
      o_wake_resume <= 1'b0;
      o_wake_vector <= 1'b0;
      case (state_reg)
        S_RST:
        begin
          state_reg <= S_VEC;
          o_vec_rd <= 1'b1;
          o_vec_addr <= VEC_ADDR_LO;
          vec_idx_reg <= 2'h0;
        end
        S_VEC:
        begin
          if (vec_idx_reg == VEC_LAST_IDX)
          begin
            o_vec_rd <= 1'b0;
            state_reg <= S_LOAD;
          end
          else
          begin
            vec_idx_reg <= vec_idx_reg + 2'h1;
            o_vec_addr <= o_vec_addr + 20'h00001;
          end
        end
        S_LOAD:
        begin
          state_reg <= S_RUN;
          o_start <= 1'b1;
          o_cpu_run <= 1'b1;
        end
        S_RUN:
        begin
          if (i_sc2_wr && i_wdata[SC2_IDLE_BIT])
          begin
            state_reg <= S_IDLE;
            o_idle <= 1'b1;
            o_cpu_run <= 1'b0;
          end
        end
        S_IDLE:
        begin
          if (wake_any)
          begin
            state_reg <= S_RUN;
            o_idle <= 1'b0;
            o_cpu_run <= 1'b1;
            o_wake_resume <= !o_imf;
            o_wake_vector <= o_imf;
          end
        end
        default:
          state_reg <= S_RST;
      endcase
    end
  end

  // Watchdog counts only while the CPU runs
  always_ff @(posedge i_clk_sys)
  begin
    if (!blk_rst_n)
      o_wdt_run <= 1'b0;
    else
      o_wdt_run <= o_wdt_enable && (state_reg == S_LOAD ||
                   (state_reg == S_RUN && !(i_sc2_wr && i_wdata[SC2_IDLE_BIT])) ||
                   (state_reg == S_IDLE && wake_any));
  end

  // PC captured at idle entry; bank selector and jump flag frozen by o_cpu_run low
  always_ff @(posedge i_clk_sys)
  begin
    if (!blk_rst_n)
      o_resume_pc <= 20'h00000;
    else if (state_reg == S_RUN && i_sc2_wr && i_wdata[SC2_IDLE_BIT])
      o_resume_pc <= i_pc_plus2;
  end

  // Vector bytes shift in low byte first
  always_ff @(posedge i_clk_sys)
  begin
    if (!blk_rst_n)
    begin
      vec_rd_d_reg <= 1'b0;
      vec_buf_reg <= 24'h000000;
    end
    else
    begin
      vec_rd_d_reg <= o_vec_rd;
      if (vec_rd_d_reg)
        vec_buf_reg <= {i_vec_rdata, vec_buf_reg[23:8]};
    end
  end
  assign o_start_pc = vec_buf_reg[19:0];

  idle_halt_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (state_reg == S_IDLE) |-> (!o_cpu_run && !o_wdt_run && o_periph_run))
    else $error("idle did not halt cpu and watchdog");
  idle_pc_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (state_reg == S_IDLE && $past(state_reg) == S_IDLE) |-> $stable(o_resume_pc))
    else $error("resume pc moved in idle");
  wake_plain_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (state_reg == S_IDLE && wake_any && !o_imf && o_core_rst_n && cause == '0) |=>
    (o_wake_resume && !o_wake_vector && o_cpu_run)) else $error("plain wake wrong");
  wake_vec_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (state_reg == S_IDLE && wake_any && o_imf && o_core_rst_n && cause == '0) |=>
    (o_wake_vector && !o_wake_resume && o_cpu_run)) else $error("vector wake wrong");
  ext_reset_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    ext_rst_reg |=> (!o_core_rst_n ##1 state_reg == S_RST)) else $error("pin reset missed");
  sysclk_guard_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (!o_hf_osc_enable || o_sysclk_select) |=> !o_core_rst_n)
    else $error("clock guard reset missed");
  reset_vals_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !o_core_rst_n |=> (!o_bank_selector && o_jump_status_flag && o_ef == '0 && o_wdt_enable))
    else $error("reset values wrong");
  vec_fetch_a: assert property (@(posedge i_clk_sys) disable iff (!blk_rst_n)
    (state_reg == S_RST) |=> (o_vec_rd && o_vec_addr == VEC_ADDR_LO) ##4 o_start)
    else $error("vector fetch sequence wrong");
endmodule : imr_core
`default_nettype wire

// ### include/imr_pkg.sv
/*
  Shared constants and types for the idle and reset control block.
  Assumes a 100 MHz system clock and a 20-bit instruction address space.
*/
package imr_pkg;
  // Clock period and external reset filter
  localparam int CLK_NS = 10;
  localparam int EXT_LOW_NS = 120; // Three machine cycles, 12/fc at fc = 100 MHz
  localparam int EXT_LOW_CYC = (EXT_LOW_NS + CLK_NS - 1) / CLK_NS;
  // Cycles without any cause before the core leaves reset
  localparam int REL_CYC = 2;
  // Reset vector, three bytes, low byte first
  localparam logic [19:0] VEC_ADDR_LO = 20'hFFFFC;
  localparam logic [1:0] VEC_LAST_IDX = 2'h2;
  // Number of maskable interrupt sources
  localparam int NSRC = 38;
  // System control two: field positions and reset value
  localparam int SC2_XEN_BIT = 7;
  localparam int SC2_SYSCLK_SELECT_BIT = 5;
  localparam int SC2_IDLE_BIT = 4;
  localparam logic SC2_XEN_RST = 1'b1;
  localparam logic SC2_SYSCLK_SELECT_RST = 1'b0;
  // Core state reset values
  localparam logic BANK_SEL_RST = 1'b0;
  localparam logic JUMP_FLAG_RST = 1'b1;
  localparam logic IMF_RST = 1'b0;
  localparam logic WDT_EN_RST = 1'b1;
  // Trapped fetch areas: RAM and SFR, then buffer regions
  localparam logic [19:0] TRAP_LOW_LO = 20'h00000;
  localparam logic [19:0] TRAP_LOW_HI = 20'h00FFF;
  localparam logic [19:0] TRAP_BUF_LO = 20'h01000;
  localparam logic [19:0] TRAP_BUF_HI = 20'h01FFF;
  // Trap prohibit codes
  localparam logic [7:0] TRAP_DIS_CODE = 8'h3C;
  localparam logic [7:0] TRAP_KEY_CODE = 8'hD4;

  // One bit for each reset cause
  typedef struct packed {
    logic ext;
    logic trap;
    logic wdt;
    logic sysclk;
    logic ofd;
  } imr_cause_s;

  // Core sequencing states, Gray along reset, fetch, run, idle
  typedef enum logic [2:0] {
    S_RST = 3'b000,
    S_VEC = 3'b001,
    S_LOAD = 3'b011,
    S_RUN = 3'b010,
    S_IDLE = 3'b110
  } imr_state_e;
endpackage : imr_pkg

// ### design/imr_rst_merge.sv
/*
  Merges the reset causes into one core reset and records the cause.
  Assumes causes are synchronous to i_clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
module imr_rst_merge (
  input wire logic i_clk_sys, // System clock
  input wire logic i_rst_n, // Power-on reset, active low
  input wire imr_pkg::imr_cause_s i_cause, // Active causes
  output logic o_core_rst_n, // Core reset, active low
  output imr_pkg::imr_cause_s o_cause // Causes of last reset
);
  import imr_pkg::*;

  logic [1:0] rel_cnt_reg;

  // Hold while any cause stands, release after a quiet spell
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      o_core_rst_n <= 1'b0;
      rel_cnt_reg <= 2'h0;
    end
    else if (|i_cause)
    begin
      o_core_rst_n <= 1'b0;
      rel_cnt_reg <= 2'h0;
    end
    else if (!o_core_rst_n)
    begin
      if (rel_cnt_reg == 2'(REL_CYC - 1))
        o_core_rst_n <= 1'b1;
      else
        rel_cnt_reg <= rel_cnt_reg + 2'h1;
    end
  end

  // Cause record; power-on leaves it clear, pin and internal causes set it after
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      o_cause <= '0;
    else if (|i_cause && o_core_rst_n)
      o_cause <= i_cause;
    else if (|i_cause)
      o_cause <= o_cause | i_cause;
  end

  // Any cause pulls the core into reset at the next edge
  cause_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (|i_cause) |=> !o_core_rst_n) else $error("cause did not reset core");
  // Release needs the cycle before it to be free of causes
  quiet_rel_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $rose(o_core_rst_n) |-> $past(i_cause) == '0) else $error("released with cause");
endmodule : imr_rst_merge
`default_nettype wire

// ### design/imr_trap_ctl.sv
/*
  Address trap: write-only permit and key, fetch area decode.
  Assumes fetch strobes come from the core in the system clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module imr_trap_ctl (
  input wire logic i_clk_sys, // System clock
  input wire logic i_rst_n, // Any reset, active low
  input wire logic i_trap_en_wr, // Write trap_enable_reg
  input wire logic i_trap_key_wr, // Write trap_key_reg
  input wire logic [7:0] i_wdata, // Write data
  input wire logic i_fetch_valid, // Instruction fetch strobe
  input wire logic [19:0] i_fetch_addr, // Fetch address
  input wire logic i_swi_exec, // software_trap_instruction runs
  input wire logic [19:0] i_swi_next_pc, // Its incremented PC
  output logic o_permit, // Trap permitted
  output logic o_trap_req // Trap reset request
);
  import imr_pkg::*;

  logic [7:0] trap_enable_reg;

  // Address lies in RAM, SFR or a buffer region
  function automatic logic in_trap_area(input logic [19:0] a);
    in_trap_area = (a >= TRAP_LOW_LO && a <= TRAP_LOW_HI) ||
                   (a >= TRAP_BUF_LO && a <= TRAP_BUF_HI);
  endfunction : in_trap_area

  // Write-only pair; key write commits the permit choice
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      trap_enable_reg <= 8'h00;
      o_permit <= 1'b1;
    end
    else
    begin
      if (i_trap_en_wr)
        trap_enable_reg <= i_wdata;
      if (i_trap_key_wr && i_wdata == TRAP_KEY_CODE)
        o_permit <= (trap_enable_reg != TRAP_DIS_CODE);
    end
  end

  // Fetch or post-increment PC inside a trapped area
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      o_trap_req <= 1'b0;
    else
      o_trap_req <= o_permit && ((i_fetch_valid && in_trap_area(i_fetch_addr)) ||
                    (i_swi_exec && in_trap_area(i_swi_next_pc)));
  end

  fetch_trap_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (o_permit && i_fetch_valid && in_trap_area(i_fetch_addr)) |=> o_trap_req)
    else $error("trapped fetch missed");
  swi_trap_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (o_permit && i_swi_exec && in_trap_area(i_swi_next_pc)) |=> o_trap_req)
    else $error("swi into trap area missed");
endmodule : imr_trap_ctl
`default_nettype wire

// ### verif/imr_vec_model.sv
/*
  Behavioural vector store beside the core: answers each vector byte read.
  Assumes reads are level requests sampled on the system clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module imr_vec_model (
  input wire logic i_clk_sys, // System clock
  input wire logic i_rd, // Vector byte read
  input wire logic [19:0] i_addr, // Vector byte address
  input wire logic [19:0] i_vec, // Vector held in store
  output logic [7:0] o_rdata // Byte, one cycle after read
);
  // Byte answered next cycle, low byte first; idle cycles toggle so stale data never matches
  always @(posedge i_clk_sys)
  begin
    if (i_rd && i_addr == 20'hFFFFC)
      o_rdata <= i_vec[7:0];
    else if (i_rd && i_addr == 20'hFFFFD)
      o_rdata <= i_vec[15:8];
    else if (i_rd && i_addr == 20'hFFFFE)
      o_rdata <= {4'h0, i_vec[19:16]};
    else
      o_rdata <= ~o_rdata;
  end
endmodule : imr_vec_model
`default_nettype wire

// ### verif/idle_mode_and_reset_control_tb_top.sv
/*
  Self-checking bench for the idle and reset control core.
  Assumes the vector store model supplies the vector bytes.
*/
`timescale 1ns/10ps
`default_nettype none
module idle_mode_and_reset_control_tb_top;
  import imr_pkg::*;
  logic i_clk_sys, i_rst_n, i_reset_pin_n, i_sc2_wr, i_trap_en_wr, i_trap_key_wr, i_ef_wr;
  logic i_imf_wr, i_imf_wdata, i_psw_wr, i_bank_sel_wdata, i_jump_flag_wdata, i_wdt_dis;
  logic i_wdt_overflow, i_ofd_low, i_ofd_high, i_fetch_valid, i_swi_exec;
  logic [7:0] i_wdata, i_vec_rdata;
  logic [NSRC-1:0] i_ef_wdata, i_irq_pending, o_ef, ef;
  logic [19:0] i_pc_plus2, i_fetch_addr, i_swi_next_pc, o_resume_pc, o_vec_addr, o_start_pc;
  logic o_core_rst_n, o_cpu_run, o_wdt_run, o_periph_run, o_idle, o_wake_resume, o_wake_vector;
  logic o_vec_rd, o_start, o_hf_osc_enable, o_sysclk_select, o_imf, o_bank_selector;
  logic o_jump_status_flag, o_wdt_enable, o_trap_permit;
  imr_cause_s o_cause;
  logic [19:0] vec;
  logic [21:0] got;
  logic [21:0] exp_q[$];
  int num_errors, tests_run, k;

  imr_core dut (.*);
  imr_vec_model u_vec (.i_clk_sys(i_clk_sys), .i_rd(o_vec_rd), .i_addr(o_vec_addr),
    .i_vec(vec), .o_rdata(i_vec_rdata));

  // Clock, 100 MHz
  always #5 i_clk_sys = ~i_clk_sys;

  task automatic chk(input string name, input logic [39:0] e, input logic [39:0] g);
    tests_run++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  task automatic finish_test;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : cyc

  // One software write: 0 control two, 1 trap enable, 2 trap key
  task automatic wr(input int which, input logic [7:0] d);
    i_wdata = d;
    case (which)
      0: i_sc2_wr = 1'b1;
      1: i_trap_en_wr = 1'b1;
      default: i_trap_key_wr = 1'b1;
    endcase
    cyc(1);
    {i_sc2_wr, i_trap_en_wr, i_trap_key_wr} = 3'b000;
    // Let an edge pass with every strobe low before the next write
    cyc(1);
  endtask : wr

  task automatic wait_rst(input logic [4:0] cause);
    for (int i = 0; i < 30 && o_core_rst_n !== 1'b0; i++)
      cyc(1);
    chk("core_rst_n", 40'h0, 40'(o_core_rst_n));
    if (o_core_rst_n !== 1'b0)
      finish_test();
    cyc(1);
    chk("cause", 40'(cause), 40'(o_cause));
  endtask : wait_rst

  // New vector each boot; start event noted for the monitor
  task automatic wait_run;
    vec = 20'($urandom);
    exp_q.push_back({2'd1, vec});
    for (int i = 0; i < 60 && o_cpu_run !== 1'b1; i++)
      cyc(1);
    chk("cpu_run", 40'h1, 40'(o_cpu_run));
    if (o_cpu_run !== 1'b1)
      finish_test();
    chk("init", 40'h8E, 40'({o_hf_osc_enable, o_sysclk_select, o_imf, o_bank_selector,
      o_jump_status_flag, o_wdt_enable, o_trap_permit, |o_ef}));
  endtask : wait_run

  // Moves core state away from its reset values
  task automatic dirty;
    i_ef_wdata = {6'h3F, 32'($urandom)};
    i_imf_wdata = 1'b1;
    {i_ef_wr, i_imf_wr, i_psw_wr, i_bank_sel_wdata, i_jump_flag_wdata} = 5'b11110;
    cyc(1);
    {i_ef_wr, i_imf_wr, i_psw_wr} = 3'b000;
    wr(1, 8'h3C);
    wr(2, 8'hD4);
  endtask : dirty

  // Monitor: each start or wake event takes the oldest note
  always @(posedge i_clk_sys)
  begin
    if (o_start === 1'b1 || o_wake_resume === 1'b1 || o_wake_vector === 1'b1)
    begin
      got = {o_wake_vector === 1'b1 ? 2'd3 : (o_wake_resume === 1'b1 ? 2'd2 : 2'd1),
        o_start === 1'b1 ? o_start_pc : 20'h0};
      if (exp_q.size() == 0)
        chk("event", 40'h0, 40'(got));
      else
        chk("event", 40'(exp_q.pop_front()), 40'(got));
    end
  end

  initial
  begin
    void'($urandom(42));
    {i_clk_sys, i_rst_n, i_sc2_wr, i_trap_en_wr, i_trap_key_wr, i_ef_wr, i_imf_wr} = '0;
    {i_imf_wdata, i_psw_wr, i_bank_sel_wdata, i_jump_flag_wdata, i_wdt_dis} = '0;
    {i_wdt_overflow, i_ofd_low, i_ofd_high, i_fetch_valid, i_swi_exec} = '0;
    {i_wdata, i_ef_wdata, i_irq_pending, i_pc_plus2, i_fetch_addr, i_swi_next_pc, vec} = '0;
    i_reset_pin_n = 1'b1;
    cyc(10);
    i_rst_n = 1'b1;
    wait_run();
    chk("por_cause", 40'h0, 40'(o_cause));
    // Watchdog disabled: overflow is ignored
    i_wdt_dis = 1'b1;
    cyc(1);
    i_wdt_dis = 1'b0;
    i_wdt_overflow = 1'b1;
    cyc(4);
    chk("wdt_off", 40'h2, 40'({o_core_rst_n, o_wdt_enable}));
    i_wdt_overflow = 1'b0;
    // Every internal cause but the trap, from dirtied state
    for (k = 0; k < 5; k++)
    begin
      dirty();
      case (k)
        0: i_ofd_low = 1'b1;
        1: i_ofd_high = 1'b1;
        2: i_wdt_overflow = 1'b1;
        3: wr(0, 8'h00);
        default: wr(0, 8'hA0);
      endcase
      wait_rst(k < 2 ? 5'h01 : (k == 2 ? 5'h04 : 5'h02));
      {i_ofd_low, i_ofd_high, i_wdt_overflow} = 3'b000;
      wait_run();
    end
    // Idle entry and wake, global enable clear then set
    for (k = 0; k < 2; k++)
    begin
      ef = '0;
      ef[$urandom_range(NSRC - 1)] = 1'b1;
      i_ef_wdata = ef;
      i_imf_wdata = k[0];
      {i_ef_wr, i_imf_wr} = 2'b11;
      i_pc_plus2 = 20'($urandom);
      cyc(1);
      {i_ef_wr, i_imf_wr} = 2'b00;
      wr(0, 8'h90);
      chk("idle", 40'h9, 40'({o_idle, o_cpu_run, o_wdt_run, o_periph_run}));
      chk("resume_pc", 40'(i_pc_plus2), 40'(o_resume_pc));
      {i_psw_wr, i_bank_sel_wdata, i_jump_flag_wdata} = 3'b110;
      i_irq_pending = ~ef;
      cyc(3);
      i_psw_wr = 1'b0;
      chk("frozen", 40'h5, 40'({o_idle, o_bank_selector, o_jump_status_flag}));
      i_irq_pending = ef;
      exp_q.push_back({k[0] ? 2'd3 : 2'd2, 20'h0});
      cyc(1);
      chk("woken", 40'h7, 40'({o_idle, o_cpu_run, o_wdt_run, o_periph_run}));
      i_irq_pending = '0;
      cyc(2);
    end
    // Reset pin while idle: short pulse refused, full pulse resets
    wr(0, 8'h90);
    i_reset_pin_n = 1'b0;
    cyc(11);
    i_reset_pin_n = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      cyc(1);
      chk("short_pin", 40'h3, 40'({o_core_rst_n, o_idle}));
    end
    i_reset_pin_n = 1'b0;
    cyc(14);
    chk("pin_rst", 40'h10, 40'({o_core_rst_n, o_cause}));
    i_reset_pin_n = 1'b1;
    wait_run();
    chk("normal", 40'h1, 40'({o_idle, o_cpu_run}));
    // Trap: wrong key, prohibit, permit again
    wr(1, 8'h3C);
    wr(2, 8'h55);
    chk("bad_key", 40'h1, 40'(o_trap_permit));
    wr(2, 8'hD4);
    chk("prohibit", 40'h0, 40'(o_trap_permit));
    i_fetch_valid = 1'b1;
    i_fetch_addr = 20'($urandom_range(20'h01FFF));
    cyc(4);
    chk("ram_exec", 40'h1, 40'(o_core_rst_n));
    i_fetch_addr = 20'h02000;
    wr(1, 8'h00);
    wr(2, 8'hD4);
    cyc(4);
    chk("outside", 40'h3, 40'({o_core_rst_n, o_trap_permit}));
    i_fetch_addr = 20'($urandom_range(20'h01FFF));
    wait_rst(5'h08);
    i_fetch_valid = 1'b0;
    wait_run();
    i_swi_next_pc = 20'($urandom_range(20'h01FFF));
    i_swi_exec = 1'b1;
    wait_rst(5'h08);
    i_swi_exec = 1'b0;
    wait_run();
    cyc(5);
    chk("events_left", 40'h0, 40'(exp_q.size()));
    finish_test();
  end
endmodule : idle_mode_and_reset_control_tb_top
`default_nettype wire
